// >>> bench/pm_plane_ctl_sva.sv
`timescale 1ns/1ps
module pm_plane_ctl_sva #(
  parameter CYC_PER_MS = 20
) (
  input wire       clock_i,
  input wire       resetn_i,
  input wire       power_button_n_i,
  input wire       button_loopback_gpio_out_i,
  input wire       button_loopback_gpio_oe_i,
  input wire       plane_ctl_a_o,
  input wire       plane_ctl_b_o,
  input wire       main_on_n_o,
  input wire       core_suspend_n_o,
  input wire       cpu_halt_o
);
  localparam int DEB_MIN = 14 * CYC_PER_MS;
  localparam int DEB_MAX = 17 * CYC_PER_MS;
  localparam int OVR_LIM = 4021 * CYC_PER_MS;
  logic [15:0] low_cnt_ff;
  logic        active_ff;
  logic        sleep_press_ff;
  wire         btn_low;
  assign btn_low = ~power_button_n_i |
                   (button_loopback_gpio_oe_i & ~button_loopback_gpio_out_i);
  // ====================================================================
  // press length, activation seen, main power off (SL4 or SL5) when the press began
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_cnt_ff <= 16'h0000;
      active_ff <= 1'b0;
      sleep_press_ff <= 1'b0;
    end else begin
      if (!btn_low)
        low_cnt_ff <= 16'h0000;
      else if (low_cnt_ff != 16'hffff)
        low_cnt_ff <= low_cnt_ff + 16'h0001;
      if (core_suspend_n_o)
        active_ff <= 1'b1;
      if (btn_low && low_cnt_ff == 16'h0000)
        sleep_press_ff <= main_on_n_o;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ====================================================================
  // assertions
  AST_PLANE_ORDER: assert property (plane_ctl_a_o |-> plane_ctl_b_o)
    else $error("plane a on while plane b off");
  AST_MAIN_OFF: assert property (main_on_n_o |-> !plane_ctl_a_o && !plane_ctl_b_o)
    else $error("main off with a plane still on");
  AST_HALT: assert property (cpu_halt_o |-> !core_suspend_n_o)
    else $error("cpu halt without core suspend");
  AST_DEB_MIN: assert property ($rose(core_suspend_n_o) |-> low_cnt_ff >= DEB_MIN)
    else $error("button accepted too early");
  AST_DEB_MAX: assert property (!active_ff && low_cnt_ff == DEB_MAX |-> core_suspend_n_o)
    else $error("activation press not accepted in time");
  AST_OVERRIDE: assert property (active_ff && low_cnt_ff == OVR_LIM |-> main_on_n_o)
    else $error("held button did not force soft off");
  AST_WAKE: assert property (sleep_press_ff && low_cnt_ff == DEB_MAX |-> !main_on_n_o)
    else $error("button press did not wake from sleep");
  AST_DROP_ALL: assert property ($rose(main_on_n_o) && $past(plane_ctl_a_o) |->
    $fell(plane_ctl_a_o) && $fell(plane_ctl_b_o))
    else $error("planes not dropped together");
endmodule // pm_plane_ctl_sva

bind pm_plane_ctl pm_plane_ctl_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (
  .clock_i                   (clock_i),
  .resetn_i                  (resetn_i),
  .power_button_n_i          (power_button_n_i),
  .button_loopback_gpio_out_i(button_loopback_gpio_out_i),
  .button_loopback_gpio_oe_i (button_loopback_gpio_oe_i),
  .plane_ctl_a_o             (plane_ctl_a_o),
  .plane_ctl_b_o             (plane_ctl_b_o),
  .main_on_n_o               (main_on_n_o),
  .core_suspend_n_o          (core_suspend_n_o),
  .cpu_halt_o                (cpu_halt_o)
);

// >>> bench/pm_switch_model.sv
`timescale 1ns/1ps
module pm_switch_model #(
  parameter CYC_PER_MS = 20
) (
  input  wire  clock_i,
  output logic power_button_n_o,
  output logic gpio_out_o,
  output logic gpio_oe_o,
  output logic thermal_alert_n_o
);
  initial begin
    power_button_n_o = 1'b1;
    gpio_out_o = 1'b1;
    gpio_oe_o = 1'b0;
    thermal_alert_n_o = 1'b1;
  end
  task automatic hold_ms(input int ms);
    repeat (ms * CYC_PER_MS) @(posedge clock_i);
  endtask
  // button low for ms, then released long enough for the release to settle
  task automatic press(input int ms);
    power_button_n_o <= 1'b0;
    hold_ms(ms);
    power_button_n_o <= 1'b1;
    hold_ms(20);
  endtask
  // software toggle through the loopback pin, kept within 16 ms to 4 s
  task automatic gpio_pulse(input int ms);
    gpio_out_o <= 1'b0;
    gpio_oe_o <= 1'b1;
    hold_ms(ms);
    gpio_oe_o <= 1'b0;
    gpio_out_o <= 1'b1;
    hold_ms(20);
  endtask
  task automatic thermal_fall;
    thermal_alert_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    thermal_alert_n_o <= 1'b1;
    repeat (4) @(posedge clock_i);
  endtask
endmodule // pm_switch_model

// >>> bench/tb_pm_plane_ctl.sv
`timescale 1ns/1ps
module tb_pm_plane_ctl;
  localparam int CYC = 10;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, last_resp;
  logic [31:0] rdata, rd_val;
  logic        btn_n, gp_out, gp_oe, therm_n, pa, pb, mon, sci, smi, core_suspend_n_n, halt;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #25 clock_i = ~clock_i;
  pm_plane_ctl #(.CYC_PER_MS(CYC)) u_dut (
    .clock_i(clock_i), .resetn_i(resetn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .power_button_n_i(btn_n),
    .button_loopback_gpio_out_i(gp_out), .button_loopback_gpio_oe_i(gp_oe),
    .thermal_alert_n_i(therm_n), .plane_ctl_a_o(pa), .plane_ctl_b_o(pb),
    .main_on_n_o(mon), .sci_o(sci), .smi_o(smi), .core_suspend_n_o(core_suspend_n_n),
    .cpu_halt_o(halt));
  pm_switch_model #(.CYC_PER_MS(CYC)) u_sw (
    .clock_i(clock_i), .power_button_n_o(btn_n), .gpio_out_o(gp_out),
    .gpio_oe_o(gp_oe), .thermal_alert_n_o(therm_n));
  // ====================================================================
  // bus and compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clock_i); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (!bvalid) @(posedge clock_i);
    last_resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock_i);
    rd_val = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    check(rd_val, exp);
  endtask
  task automatic planes(input logic a, input logic b, input logic m);
    check({29'h0, pa, pb, mon}, {29'h0, a, b, m});
  endtask
  task automatic irq(input logic [1:0] e);
    @(posedge clock_i);
    check({30'h0, sci, smi}, {30'h0, e});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      tally_and_finish;
    end
  end
  // ====================================================================
  // tests
  initial begin
    repeat (16) @(posedge clock_i);
    planes(1, 1, 0);
    check({31'h0, core_suspend_n_n}, 32'h0000_0000);
    resetn_i <= 1'b1;
    rdchk(8'h54, 32'h0000_0010);
    check({30'h0, last_resp}, 32'h0000_0000);
    rdchk(8'hfc, 32'h0000_0000);
    check({30'h0, last_resp}, 32'h0000_0002);
    wr(8'hfc, 32'hffff_ffff);
    check({30'h0, last_resp}, 32'h0000_0002);
    wr(8'h50, 32'h0000_0000);
    check({30'h0, last_resp}, 32'h0000_0000);
    $display("test reset done");
    u_sw.gpio_pulse(20);
    rdchk(8'h54, 32'h0000_0018);
    check({31'h0, halt}, 32'h0000_0000);
    for (int t = 1; t <= 5; t++) begin
      wr(8'h30, 32'h0000_2001 | (t << 10));
      planes(t < 2, t < 3, t > 3);
      u_sw.press(5);
      rdchk(8'h54, 32'h0000_0018 | t);
      u_sw.press(25);
      planes(1, 1, 0);
      rdchk(8'h20, 32'h0000_8100);
      wr(8'h20, 32'h0000_8100);
      rdchk(8'h20, 32'h0000_0000);
    end
    $display("test sleep states done");
    wr(8'h28, 32'h0000_0100);
    wr(8'h30, 32'h0000_0001);
    u_sw.press(25);
    rdchk(8'h20, 32'h0000_0100);
    irq(2'h2);
    rdchk(8'h20, 32'h0000_0100);
    wr(8'h20, 32'h0000_0100);
    irq(2'h0);
    wr(8'h30, 32'h0000_0000);
    u_sw.press(25);
    planes(0, 0, 1);
    irq(2'h1);
    wr(8'h20, 32'h0000_0100);
    u_sw.press(25);
    planes(1, 1, 0);
    rdchk(8'h20, 32'h0000_8100);
    wr(8'h20, 32'h0000_8100);
    wr(8'h28, 32'h0000_0000);
    $display("test button done");
    wstrb <= 4'h1;
    wr(8'h30, 32'h0000_2c01);
    wstrb <= 4'hf;
    rdchk(8'h30, 32'h0000_0001);
    rdchk(8'h54, 32'h0000_0018);
    wr(8'h48, 32'h0000_0020);
    u_sw.thermal_fall;
    rdchk(8'h40, 32'h0000_0020);
    irq(2'h2);
    wr(8'h40, 32'h0000_0020);
    irq(2'h0);
    $display("test thermal done");
    wr(8'h30, 32'h0000_0001);
    u_sw.press(4025);
    rdchk(8'h20, 32'h0000_0800);
    planes(0, 0, 1);
    irq(2'h2);
    wr(8'h30, 32'h0000_0000);
    irq(2'h2);
    wr(8'h50, 32'h0000_0001);
    check({30'h0, core_suspend_n_n, halt}, 32'h0000_0001);
    wr(8'h20, 32'h0000_0800);
    irq(2'h0);
    $display("test override done");
    tally_and_finish;
  end
endmodule // tb_pm_plane_ctl

// >>> hdl/pm_plane_ctl.v
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "pm_plane_defines.vh"
module pm_plane_ctl #(
  parameter CYC_PER_MS = `CLK_FREQ_KHZ
) (
  input  wire        clock_i,
  input  wire        resetn_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire        power_button_n_i,
  input  wire        button_loopback_gpio_out_i,
  input  wire        button_loopback_gpio_oe_i,
  input  wire        thermal_alert_n_i,
  output wire        plane_ctl_a_o,
  output wire        plane_ctl_b_o,
  output wire        main_on_n_o,
  output wire        sci_o,
  output wire        smi_o,
  output wire        core_suspend_n_o,
  output wire        cpu_halt_o
);

  // ===================================================================
  // bus slave
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         rvalid_ff;
  reg  [1:0]  rresp_ff;
  reg  [31:0] rdata_ff;
  wire        wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_ff;
  wire        rd_go = s_axi_arvalid_i & ~rvalid_ff;
  wire [5:0]  widx  = s_axi_awaddr_i[7:2];
  wire [5:0]  ridx  = s_axi_araddr_i[7:2];
  wire [31:0] wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                       {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
  wire [31:0] wbits = s_axi_wdata_i & wmask;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o  = wr_go;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_arready_o = rd_go;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign s_axi_rdata_o   = rdata_ff;
  wire w_status  = wr_go & (widx == `IDX_STATUS);
  wire w_enable  = wr_go & (widx == `IDX_ENABLE);
  wire w_control = wr_go & (widx == `IDX_CONTROL);
  wire w_th_sts  = wr_go & (widx == `IDX_THERM_STS);
  wire w_th_en   = wr_go & (widx == `IDX_THERM_EN);
  wire w_misc    = wr_go & (widx == `IDX_MISC_CTL);
  wire w_state   = wr_go & (widx == `IDX_STATE);
  wire w_hit     = w_status | w_enable | w_control | w_th_sts | w_th_en | w_misc | w_state;

  // ===================================================================
  // software state
  reg        button_status_ff;
  reg        override_status_ff;
  reg        wake_status_ff;
  reg        thermal_status_ff;
  reg        button_enable_ff;
  reg        thermal_enable_ff;
  reg        sci_select_ff;
  reg  [2:0] sleep_type_sel_ff;
  reg        suspend_pin_use_ff;
  reg  [2:0] state_ff;
  reg        acpi_active_ff;
  wire       sleep_go = w_control & wbits[`BIT_SLEEP_GO];
  wire [2:0] req_type = s_axi_wdata_i[`FLD_SLEEP_HI:`FLD_SLEEP_LO];
  wire       typ_lane = s_axi_wstrb_i[1];

  // ===================================================================
  // millisecond tick
  reg  [14:0] ms_cnt_ff;
  wire        ms_tick = (ms_cnt_ff == CYC_PER_MS - 1);
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_cnt_ff <= 15'h0000;
    end else begin
      ms_cnt_ff <= ms_tick ? 15'h0000 : ms_cnt_ff + 15'h0001;
    end
  end

  // ===================================================================
  // button input, loopback and debounce
  wire        raw_button = power_button_n_i &
                           ~(button_loopback_gpio_oe_i & ~button_loopback_gpio_out_i);
  reg         raw_prev_ff;
  reg         db_level_ff;
  reg  [4:0]  db_cnt_ff;
  reg  [12:0] ovr_cnt_ff;
  reg         therm_prev_ff;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      raw_prev_ff <= 1'b1;
      db_level_ff <= 1'b1;
      db_cnt_ff   <= 5'h00;
    end else begin
      raw_prev_ff <= raw_button;
      if (raw_button != raw_prev_ff || raw_button == db_level_ff) begin
        db_cnt_ff <= 5'h00;
      end else if (db_cnt_ff == `DEBOUNCE_MS) begin
        db_level_ff <= raw_button;
        db_cnt_ff   <= 5'h00;
      end else if (ms_tick) begin
        db_cnt_ff <= db_cnt_ff + 5'h01;
      end
    end
  end
  wire db_fall   = (db_cnt_ff == `DEBOUNCE_MS) && !raw_button && db_level_ff &&
                   (raw_button == raw_prev_ff);
  wire btn_event = db_fall & acpi_active_ff;
  wire asleep    = (state_ff != `ST_S0);
  wire btn_wake  = btn_event & asleep;
  wire btn_sleep = btn_event & ~asleep;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovr_cnt_ff <= 13'h0000;
    end else if (db_level_ff || !acpi_active_ff) begin
      ovr_cnt_ff <= 13'h0000;
    end else if (ms_tick && ovr_cnt_ff <= `OVERRIDE_MS) begin
      ovr_cnt_ff <= ovr_cnt_ff + 13'h0001;
    end
  end
  wire ovr_event = ms_tick && !db_level_ff && acpi_active_ff &&
                   (ovr_cnt_ff == `OVERRIDE_MS);

  // ===================================================================
  // thermal edge
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      therm_prev_ff <= 1'b1;
    end else begin
      therm_prev_ff <= thermal_alert_n_i;
    end
  end
  wire therm_event = therm_prev_ff & ~thermal_alert_n_i & acpi_active_ff;
  wire therm_wake  = therm_event & thermal_enable_ff & (state_ff == `ST_SL1);

  // ===================================================================
  // sleep state machine
  reg [2:0] nxt_state;
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `ST_S0: begin
        if (ovr_event || (btn_sleep && !sci_select_ff)) begin
          nxt_state = `ST_SL5;
        end else if (sleep_go && typ_lane && req_type >= `ST_SL1 && req_type <= `ST_SL5) begin
          nxt_state = req_type;
        end
      end
      `ST_SL1, `ST_SL2, `ST_SL3, `ST_SL4, `ST_SL5: begin
        if (ovr_event) begin
          nxt_state = `ST_SL5;
        end else if (btn_wake || therm_wake) begin
          nxt_state = `ST_S0;
        end
      end
      default: nxt_state = `ST_S0;
    endcase
  end
  reg plane_a_ff;
  reg plane_b_ff;
  reg main_on_n_ff;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff     <= `ST_S0;
      plane_a_ff   <= 1'b1;
      plane_b_ff   <= 1'b1;
      main_on_n_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      plane_a_ff   <= (nxt_state <= `ST_SL1);
      plane_b_ff   <= (nxt_state <= `ST_SL2);
      main_on_n_ff <= (nxt_state >= `ST_SL4);
    end
  end

  // ===================================================================
  // status, enable and control registers
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acpi_active_ff     <= 1'b0;
      button_status_ff   <= 1'b0;
      override_status_ff <= 1'b0;
      wake_status_ff     <= 1'b0;
      thermal_status_ff  <= 1'b0;
      button_enable_ff   <= 1'b0;
      thermal_enable_ff  <= 1'b0;
      sci_select_ff      <= 1'b0;
      sleep_type_sel_ff  <= 3'h0;
      suspend_pin_use_ff <= 1'b0;
    end else begin
      acpi_active_ff <= acpi_active_ff | db_fall;
      if (ovr_event) begin
        button_status_ff <= 1'b0;
      end else if (btn_event) begin
        button_status_ff <= 1'b1;
      end else if (w_status && wbits[`BIT_BUTTON_STS]) begin
        button_status_ff <= 1'b0;
      end
      override_status_ff <= ovr_event |
        (override_status_ff & ~(w_status & wbits[`BIT_OVERRIDE]));
      wake_status_ff <= (asleep & (nxt_state == `ST_S0)) |
        (wake_status_ff & ~(w_status & wbits[`BIT_WAKE_STS]));
      thermal_status_ff <= therm_event |
        (thermal_status_ff & ~(w_th_sts & wbits[`BIT_THERMAL]));
      if (w_enable && s_axi_wstrb_i[1]) begin
        button_enable_ff <= s_axi_wdata_i[`BIT_BUTTON_EN];
      end
      if (w_th_en && s_axi_wstrb_i[0]) begin
        thermal_enable_ff <= s_axi_wdata_i[`BIT_THERMAL];
      end
      if (w_control && s_axi_wstrb_i[0]) begin
        sci_select_ff <= s_axi_wdata_i[`BIT_SCI_SELECT];
      end
      if (w_control && typ_lane) begin
        sleep_type_sel_ff <= req_type;
      end
      if (w_misc && s_axi_wstrb_i[0]) begin
        suspend_pin_use_ff <= s_axi_wdata_i[`BIT_CORE_SUSPEND_N_USE];
      end
    end
  end

  // ===================================================================
  // interrupt routing and core suspend
  wire mixed_pend = (button_status_ff & button_enable_ff) |
                    (thermal_status_ff & thermal_enable_ff);
  reg  sci_ff;
  reg  smi_ff;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sci_ff <= 1'b0;
      smi_ff <= 1'b0;
    end else begin
      sci_ff <= acpi_active_ff & (override_status_ff | (sci_select_ff & mixed_pend));
      smi_ff <= acpi_active_ff & ~sci_select_ff & mixed_pend;
    end
  end
  assign plane_ctl_a_o    = plane_a_ff;
  assign plane_ctl_b_o    = plane_b_ff;
  assign main_on_n_o      = main_on_n_ff;
  assign sci_o            = sci_ff;
  assign smi_o            = smi_ff;
  assign core_suspend_n_o = acpi_active_ff & ~asleep;
  assign cpu_halt_o       = ~core_suspend_n_o & suspend_pin_use_ff;

  // ===================================================================
  // bus responses and read mux
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (ridx)
      `IDX_STATUS: begin
        rd_mux[`BIT_BUTTON_STS] = button_status_ff;
        rd_mux[`BIT_OVERRIDE]   = override_status_ff;
        rd_mux[`BIT_WAKE_STS]   = wake_status_ff;
      end
      `IDX_ENABLE:    rd_mux[`BIT_BUTTON_EN] = button_enable_ff;
      `IDX_CONTROL: begin
        rd_mux[`BIT_SCI_SELECT]                 = sci_select_ff;
        rd_mux[`FLD_SLEEP_HI:`FLD_SLEEP_LO]     = sleep_type_sel_ff;
      end
      `IDX_THERM_STS: rd_mux[`BIT_THERMAL]  = thermal_status_ff;
      `IDX_THERM_EN:  rd_mux[`BIT_THERMAL]  = thermal_enable_ff;
      `IDX_MISC_CTL:  rd_mux[`BIT_CORE_SUSPEND_N_USE] = suspend_pin_use_ff;
      `IDX_STATE:     rd_mux[4:0] = {db_level_ff, acpi_active_ff, state_ff};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end
  wire r_hit = (ridx == `IDX_STATUS) | (ridx == `IDX_ENABLE) | (ridx == `IDX_CONTROL) |
               (ridx == `IDX_THERM_STS) | (ridx == `IDX_THERM_EN) |
               (ridx == `IDX_MISC_CTL) | (ridx == `IDX_STATE);
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff  <= `RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
        rdata_ff  <= rd_mux;
      end else if (s_axi_rready_i) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule // pm_plane_ctl

// >>> inc/pm_plane_defines.vh
`ifndef PM_PLANE_DEFINES_VH
`define PM_PLANE_DEFINES_VH

// =====================================================================
// register indices, byte address is four times the index
`define IDX_STATUS      6'h08
`define IDX_ENABLE      6'h0A
`define IDX_CONTROL     6'h0C
`define IDX_THERM_STS   6'h10
`define IDX_THERM_EN    6'h12
`define IDX_MISC_CTL    6'h14
`define IDX_STATE       6'h15

// =====================================================================
// field positions
`define BIT_BUTTON_STS  8
`define BIT_OVERRIDE    11
`define BIT_WAKE_STS    15
`define BIT_BUTTON_EN   8
`define BIT_SCI_SELECT  0
`define FLD_SLEEP_LO    10
`define FLD_SLEEP_HI    12
`define BIT_SLEEP_GO    13
`define BIT_THERMAL     5
`define BIT_CORE_SUSPEND_N_USE    0

// =====================================================================
// sleep state encodings
`define ST_S0           3'h0
`define ST_SL1          3'h1
`define ST_SL2          3'h2
`define ST_SL3          3'h3
`define ST_SL4          3'h4
`define ST_SL5          3'h5

// =====================================================================
// timing
`define CLK_FREQ_KHZ    20000
`define DEBOUNCE_MS     15
`define OVERRIDE_MS     4000

// =====================================================================
// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif
